// ==== dv/programmable_relay_sequencer_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module programmable_relay_sequencer_tb;
  import prs_pkg::*;
  localparam logic [ID_W-1:0] TB_ID = 32'h0000_3C5A; // Arbitrary value
  logic clk, rst, in_a, in_b, want_a, want_b, prog_we;
  logic [ADDR_W-1:0] prog_addr;
  logic [WORD_W-1:0] prog_data;
  logic relay_on, running, halted;
  logic [ADDR_W-1:0] step;
  logic [ID_W-1:0] unit_id;
  int errors = 0;
  int total_checks = 0;

  prs_sequencer #(.TICK_CYC(4), .UNIT_ID(TB_ID)) dut (
    .clk(clk), .rst(rst), .in_a(in_a), .in_b(in_b), .prog_we(prog_we),
    .prog_addr(prog_addr), .prog_data(prog_data), .relay_on(relay_on),
    .running(running), .halted(halted), .step(step), .unit_id(unit_id)
  );
  prs_far_side far (
    .clk(clk), .want_a(want_a), .want_b(want_b), .in_a(in_a), .in_b(in_b)
  );

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic end_sim;
    if (errors == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    prog_we <= 1'b1;
    prog_addr <= a;
    prog_data <= d;
    @(posedge clk);
    prog_we <= 1'b0;
  endtask : wr

  task automatic wait_step(input logic [7:0] s, input int n);
    int i;
    for (i = 0; i < n && step !== s; i++) begin
      @(negedge clk);
    end
    chk({24'h00_0000, step}, {24'h00_0000, s});
  endtask : wait_step

  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask : idle

  // Program held across reset, fixed relay and step at start
  task automatic t_power_up;
    wr(8'h00, {OP_OUT, ACT_ON, 1'b0, 25'h000_0000});
    wr(8'h01, {OP_IN, 1'b0, 1'b1, 26'h000_0000});
    wr(8'h02, {OP_OUT, ACT_TOGGLE, 1'b1, 5'h00, 20'h0_0001});
    wr(8'h03, {OP_PAUSE, 8'h00, 20'h0_0001});
    wr(8'h04, {OP_RET, 4'h0, 16'h0001, 8'h03});
    wr(8'h05, {OP_OUT, ACT_OFF, 1'b0, 25'h000_0000});
    wr(8'h06, {OP_STOP, 28'h000_0000});
    wr(8'hC8, {OP_RESET, 28'h000_0000});
    idle(2);
    chk({31'h0, relay_on}, {31'h0, RELAY_RST});
    chk({24'h00_0000, step}, {24'h00_0000, PC_RST});
    chk({31'h0, halted}, 32'h0000_0000);
    chk(unit_id, TB_ID);
  endtask : t_power_up

  // Permanent output then a held input wait
  task automatic t_out_and_wait;
    @(posedge clk);
    rst <= 1'b0;
    wait_step(8'h01, 20);
    chk({31'h0, relay_on}, 32'h0000_0001);
    idle(20);
    chk({24'h00_0000, step}, 32'h0000_0001);
    @(posedge clk);
    want_a <= 1'b1;
    wait_step(8'h02, 12);
  endtask : t_out_and_wait

  // Timed toggle restores the earlier level when it runs out
  task automatic t_timed;
    idle(2);
    chk({31'h0, relay_on}, 32'h0000_0000);
    wait_step(8'h03, 12);
    chk({31'h0, relay_on}, 32'h0000_0001);
  endtask : t_timed

  // Body of pause and return runs count plus one times
  task automatic t_loop;
    int visits;
    int i;
    logic [7:0] prev;
    visits = 1;
    prev = step;
    for (i = 0; i < 200 && step !== 8'h05; i++) begin
      @(negedge clk);
      if (step === 8'h03 && prev !== 8'h03) visits++;
      prev = step;
    end
    chk(visits, 2);
  endtask : t_loop

  // Stop halts for good; a new program loads while halted
  task automatic t_stop;
    int i;
    for (i = 0; i < 40 && halted !== 1'b1; i++) @(negedge clk);
    chk({31'h0, halted}, 32'h0000_0001);
    chk({31'h0, relay_on}, 32'h0000_0000);
    chk({31'h0, running}, 32'h0000_0000);
    wr(8'h00, {OP_SPEC, 1'b1, 1'b0, 1'b1, 1'b1, 24'h00_0000});
    wr(8'h01, {OP_OUT, ACT_TOGGLE, 1'b0, 25'h000_0000});
    wr(8'h02, {OP_RESET, 28'h000_0000});
    chk({31'h0, halted}, 32'h0000_0001);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    idle(2);
    chk({31'h0, halted}, 32'h0000_0000);
  endtask : t_stop

  // Reset command loops back; special pause freezes; special reset restarts
  task automatic t_special;
    logic [7:0] held;
    int i;
    wait_step(8'h02, 20);
    wait_step(8'h00, 10);
    wait_step(8'h01, 10);
    @(posedge clk);
    want_b <= 1'b1;
    idle(8);
    held = step;
    idle(20);
    chk({24'h00_0000, step}, {24'h00_0000, held});
    chk({31'h0, running}, 32'h0000_0000);
    @(posedge clk);
    want_b <= 1'b0;
    idle(8);
    chk({31'h0, running}, 32'h0000_0001);
    wr(8'h01, {OP_SPEC, 1'b0, 1'b1, 1'b1, 1'b0, 24'h00_0000});
    wr(8'h02, {OP_IN, 1'b0, 1'b0, 26'h000_0000});
    idle(16);
    chk({24'h00_0000, step}, 32'h0000_0002);
    @(posedge clk);
    want_a <= 1'b0;
    wait_step(8'h00, 10);
    for (i = 0; i < 80 && halted !== 1'b1; i++) @(negedge clk);
    chk({31'h0, halted}, 32'h0000_0001);
    chk({31'h0, relay_on}, 32'h0000_0000);
  endtask : t_special

  initial begin
    rst = 1'b1;
    want_a = 1'b0;
    want_b = 1'b0;
    prog_we = 1'b0;
    prog_addr = 8'h00;
    prog_data = 32'h0000_0000;
    fork
      begin
        repeat (20) @(posedge clk);
      end
      t_power_up();
    join
    t_out_and_wait();
    t_timed();
    t_loop();
    t_stop();
    t_special();
    end_sim();
  end

  initial begin
    #800_000;
    errors++;
    end_sim();
  end
endmodule : programmable_relay_sequencer_tb
`default_nettype wire

// ==== dv/prs_far_side.sv ====
`timescale 1ns/1ps
`default_nettype none
module prs_far_side (
  input wire logic clk,
  input wire logic want_a,
  input wire logic want_b,
  output logic in_a,
  output logic in_b
);
  // Two independent switched inputs, changed just after an edge
  always_ff @(posedge clk) begin
    in_a <= want_a;
    in_b <= want_b;
  end
endmodule : prs_far_side
`default_nettype wire

// ==== hw/prs_pkg.sv ====
`default_nettype none
package prs_pkg;
  localparam int PROG_DEPTH = 200;
  localparam int ADDR_W = 8;
  localparam int WORD_W = 32;
  localparam int DUR_W = 20;
  localparam int CNT_W = 16;
  localparam int ID_W = 32;
  // Time base
  localparam int CLK_NS = 40;
  localparam int TICK_NS = 100_000_000;
  localparam int TICK_CYC = TICK_NS / CLK_NS;
  localparam logic [DUR_W-1:0] DUR_MIN = 20'h0_0001;
  localparam logic [DUR_W-1:0] DUR_MAX = 20'hD_2F00;
  // Command word fields
  localparam int F_OP_HI = 31;
  localparam int F_OP_LO = 28;
  localparam int F_ACT_HI = 27;
  localparam int F_ACT_LO = 26;
  localparam int F_TIMED = 25;
  localparam int F_SEL = 27;
  localparam int F_LVL = 26;
  localparam int F_SACT = 26;
  localparam int F_SEN = 25;
  localparam int F_SLVL = 24;
  localparam int F_CNT_HI = 23;
  localparam int F_CNT_LO = 8;
  localparam int F_TGT_HI = 7;
  localparam int F_TGT_LO = 0;
  localparam int F_DUR_HI = 19;
  localparam int F_DUR_LO = 0;
  // Opcodes
  localparam logic [3:0] OP_OUT = 4'h0;
  localparam logic [3:0] OP_IN = 4'h1;
  localparam logic [3:0] OP_RET = 4'h2;
  localparam logic [3:0] OP_PAUSE = 4'h3;
  localparam logic [3:0] OP_STOP = 4'h4;
  localparam logic [3:0] OP_RESET = 4'h5;
  localparam logic [3:0] OP_SPEC = 4'h6;
  // Output actions
  localparam logic [1:0] ACT_ON = 2'h0;
  localparam logic [1:0] ACT_OFF = 2'h1;
  localparam logic [1:0] ACT_TOGGLE = 2'h2;
  // Reset values
  localparam logic RELAY_RST = 1'b0;
  localparam logic [ADDR_W-1:0] PC_RST = 8'h00;
  localparam logic [ID_W-1:0] UNIT_ID_DEF = 32'h0000_5A17; // Arbitrary value
  typedef enum logic [2:0] {
    ST_FETCH = 3'b000,
    ST_EXEC = 3'b001,
    ST_WAIT_TIME = 3'b010,
    ST_WAIT_IN = 3'b011,
    ST_HALT = 3'b100
  } prs_state_t;
endpackage : prs_pkg
`default_nettype wire

// ==== hw/prs_sequencer.sv ====
`timescale 1ns/1ps
`default_nettype none
module prs_sequencer #(
  parameter int TICK_CYC = prs_pkg::TICK_CYC,
  parameter logic [prs_pkg::ID_W-1:0] UNIT_ID = prs_pkg::UNIT_ID_DEF
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_a,
  input wire logic in_b,
  input wire logic prog_we,
  input wire logic [prs_pkg::ADDR_W-1:0] prog_addr,
  input wire logic [prs_pkg::WORD_W-1:0] prog_data,
  output logic relay_on,
  output logic running,
  output logic halted,
  output logic [prs_pkg::ADDR_W-1:0] step,
  output logic [prs_pkg::ID_W-1:0] unit_id
);
  import prs_pkg::*;

  logic [WORD_W-1:0] mem [PROG_DEPTH];
  logic [WORD_W-1:0] cmd;
  logic [CNT_W-1:0] rep [PROG_DEPTH];
  prs_state_t state;
  logic [ADDR_W-1:0] pc;
  logic [1:0] in_s1, in_s2, act, act_prev;
  logic [1:0] spec_en, spec_rst, spec_lvl;
  logic hold, sreset, exec_go, at_end, jump, restart;
  logic relay_saved, timed_out, tmr_busy, tmr_start;
  logic [3:0] op;
  logic [1:0] out_act;
  logic [ADDR_W-1:0] tgt, next_pc;
  logic [CNT_W-1:0] cnt;
  logic [DUR_W-1:0] dur_raw, dur;
  logic sel_lvl;

  // Input synchronisers and special-input activation
  for (genvar i = 0; i < 2; i++) begin : g_in
    always_ff @(posedge clk) begin
      if (rst) begin
        in_s1[i] <= 1'b0;
        in_s2[i] <= 1'b0;
        act_prev[i] <= 1'b0;
      end else begin
        in_s1[i] <= (i == 0) ? in_a : in_b;
        in_s2[i] <= in_s1[i];
        act_prev[i] <= act[i];
      end
    end
    assign act[i] = spec_en[i] && (in_s2[i] == spec_lvl[i]);
  end

  assign hold = |(act & ~spec_rst);
  assign sreset = |(act & ~act_prev & spec_rst) && state != ST_HALT;

  assign op = cmd[F_OP_HI:F_OP_LO];
  assign out_act = cmd[F_ACT_HI:F_ACT_LO];
  assign tgt = cmd[F_TGT_HI:F_TGT_LO];
  assign cnt = cmd[F_CNT_HI:F_CNT_LO];
  assign dur_raw = cmd[F_DUR_HI:F_DUR_LO];
  assign sel_lvl = cmd[F_SEL] ? in_s2[1] : in_s2[0];
  assign exec_go = state == ST_EXEC && !hold && !sreset;
  assign at_end = pc == ADDR_W'(PROG_DEPTH - 1);
  assign next_pc = pc + 8'h01;
  assign jump = tgt < pc && (cnt == '0 || rep[pc] < cnt);
  assign restart = sreset || (exec_go && op == OP_RESET);

  always_comb begin
    dur = dur_raw;
    if (dur_raw > DUR_MAX) begin
      dur = DUR_MAX;
    end else if (dur_raw < DUR_MIN) begin
      dur = DUR_MIN;
    end
  end

  assign tmr_start = exec_go &&
    ((op == OP_OUT && cmd[F_TIMED]) || op == OP_PAUSE);

  // Program store, written by the wireless loader at any time
  always_ff @(posedge clk) begin
    if (prog_we && prog_addr < ADDR_W'(PROG_DEPTH)) begin
      mem[prog_addr] <= prog_data;
    end
    cmd <= mem[pc];
  end

  // Sequencing
  always_ff @(posedge clk) begin
    if (rst) begin
      state <= ST_FETCH;
      pc <= PC_RST;
    end else if (sreset) begin
      state <= ST_FETCH;
      pc <= PC_RST;
    end else if (!hold) begin
      unique case (state)
        ST_FETCH: state <= ST_EXEC;
        ST_EXEC: begin
          unique case (op)
            OP_OUT, OP_SPEC: begin
              if (op == OP_OUT && cmd[F_TIMED]) begin
                state <= ST_WAIT_TIME;
              end else if (at_end) begin
                state <= ST_HALT;
              end else begin
                pc <= next_pc;
                state <= ST_FETCH;
              end
            end
            OP_IN: state <= ST_WAIT_IN;
            OP_RET: begin
              if (jump) begin
                pc <= tgt;
                state <= ST_FETCH;
              end else if (at_end) begin
                state <= ST_HALT;
              end else begin
                pc <= next_pc;
                state <= ST_FETCH;
              end
            end
            OP_PAUSE: state <= ST_WAIT_TIME;
            OP_STOP: state <= ST_HALT;
            OP_RESET: begin
              pc <= PC_RST;
              state <= ST_FETCH;
            end
            default: state <= ST_HALT;
          endcase
        end
        ST_WAIT_TIME: begin
          if (!tmr_busy) begin
            if (at_end) begin
              state <= ST_HALT;
            end else begin
              pc <= next_pc;
              state <= ST_FETCH;
            end
          end
        end
        ST_WAIT_IN: begin
          if (sel_lvl == cmd[F_LVL]) begin
            if (at_end) begin
              state <= ST_HALT;
            end else begin
              pc <= next_pc;
              state <= ST_FETCH;
            end
          end
        end
        ST_HALT: state <= ST_HALT;
      endcase
    end
  end

  // Relay contact
  always_ff @(posedge clk) begin
    if (rst) begin
      relay_on <= RELAY_RST;
      relay_saved <= RELAY_RST;
      timed_out <= 1'b0;
    end else if (sreset && timed_out) begin
      relay_on <= relay_saved;
      timed_out <= 1'b0;
    end else if (exec_go && op == OP_OUT) begin
      relay_saved <= relay_on;
      timed_out <= cmd[F_TIMED];
      unique case (out_act)
        ACT_ON: relay_on <= 1'b1;
        ACT_OFF: relay_on <= 1'b0;
        ACT_TOGGLE: relay_on <= !relay_on;
        default: relay_on <= relay_on;
      endcase
    end else if (timed_out && state == ST_WAIT_TIME && !tmr_busy && !hold) begin
      relay_on <= relay_saved;
      timed_out <= 1'b0;
    end
  end

  // Repeat counters, one per return step
  always_ff @(posedge clk) begin
    if (rst || restart) begin
      for (int k = 0; k < PROG_DEPTH; k++) begin
        rep[k] <= '0;
      end
    end else if (exec_go && op == OP_RET && cnt != '0 && tgt < pc) begin
      if (rep[pc] < cnt) begin
        rep[pc] <= rep[pc] + 16'h0001;
      end else begin
        rep[pc] <= '0;
      end
    end
  end

  // Special input configuration
  always_ff @(posedge clk) begin
    if (rst) begin
      spec_en <= 2'h0;
      spec_rst <= 2'h0;
      spec_lvl <= 2'h0;
    end else if (exec_go && op == OP_SPEC) begin
      spec_en[cmd[F_SEL]] <= cmd[F_SEN];
      spec_rst[cmd[F_SEL]] <= cmd[F_SACT];
      spec_lvl[cmd[F_SEL]] <= cmd[F_SLVL];
    end
  end

  // Status outputs
  always_ff @(posedge clk) begin
    if (rst) begin
      running <= 1'b0;
      halted <= 1'b0;
      step <= PC_RST;
      unit_id <= UNIT_ID;
    end else begin
      running <= state != ST_HALT && !hold;
      halted <= state == ST_HALT;
      step <= pc;
      unit_id <= UNIT_ID;
    end
  end

  prs_timer #(
    .TICK_CYC(TICK_CYC)
  ) u_timer (
    .clk(clk),
    .rst(rst),
    .start(tmr_start),
    .clear(sreset),
    .freeze(hold),
    .dur(dur),
    .busy(tmr_busy)
  );

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_exec_op(logic [3:0] o);
    exec_go && op == o;
  endsequence

  sequence s_back_to_start;
    pc == PC_RST && state == ST_FETCH;
  endsequence

  relay_power_a: assert property (disable iff (1'b0)
    rst |=> !relay_on && pc == PC_RST && !tmr_busy)
    else $error("relay or pc not cleared after reset");
  stop_holds_a: assert property (
    state == ST_HALT |=> state == ST_HALT && $stable(pc))
    else $error("halted program moved");
  reset_cmd_a: assert property (
    s_exec_op(OP_RESET) |=> s_back_to_start)
    else $error("reset command did not restart");
  wait_input_a: assert property (
    state == ST_WAIT_IN && sel_lvl != cmd[F_LVL] && !sreset
    |=> state == ST_WAIT_IN && $stable(pc))
    else $error("input wait left early");
  out_on_a: assert property (
    s_exec_op(OP_OUT) && out_act == ACT_ON |=> relay_on)
    else $error("relay not energised");
  relay_toggle_a: assert property (
    s_exec_op(OP_OUT) && out_act == ACT_TOGGLE
    |=> relay_on != $past(relay_on))
    else $error("relay not toggled");
  spec_pause_a: assert property (
    hold && !sreset && state != ST_FETCH |=> $stable(pc) && $stable(state))
    else $error("special pause did not hold");
  spec_reset_a: assert property (
    sreset |=> s_back_to_start)
    else $error("special reset did not restart");
  loop_jump_a: assert property (
    s_exec_op(OP_RET) && jump |=> pc == $past(tgt))
    else $error("return did not jump back");
  pause_wait_a: assert property (
    s_exec_op(OP_PAUSE) |=> state == ST_WAIT_TIME && tmr_busy)
    else $error("pause did not start timer");
  store_write_a: assert property (
    prog_we && prog_addr < ADDR_W'(PROG_DEPTH)
    |=> mem[$past(prog_addr)] == $past(prog_data))
    else $error("program word not stored");
  unit_id_a: assert property (
    unit_id == UNIT_ID)
    else $error("unit identifier wrong");
endmodule : prs_sequencer
`default_nettype wire

// ==== hw/prs_timer.sv ====
`timescale 1ns/1ps
`default_nettype none
module prs_timer #(
  parameter int TICK_CYC = prs_pkg::TICK_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire logic clear,
  input wire logic freeze,
  input wire logic [prs_pkg::DUR_W-1:0] dur,
  output logic busy
);
  import prs_pkg::*;
  localparam int PW = $clog2(TICK_CYC + 1);
  localparam logic [PW-1:0] PRE_LAST = PW'(TICK_CYC - 1);
  logic [PW-1:0] pre;
  logic [DUR_W-1:0] remain;

  // Counts whole 0.1 s ticks; frozen while execution is held
  always_ff @(posedge clk) begin
    if (rst || clear) begin
      busy <= 1'b0;
      pre <= '0;
      remain <= '0;
    end else if (start) begin
      busy <= 1'b1;
      pre <= '0;
      remain <= dur;
    end else if (busy && !freeze) begin
      if (pre == PRE_LAST) begin
        pre <= '0;
        remain <= remain - 20'h0_0001;
        if (remain == DUR_MIN) begin
          busy <= 1'b0;
        end
      end else begin
        pre <= pre + PW'(1);
      end
    end
  end
endmodule : prs_timer
`default_nettype wire
